// ==== hdl/bscr_defines.vh ====
// bscr_defines.vh: constants for the banked serial control register
// assumes: included by bare name from the design files under hdl/
`ifndef BSCR_DEFINES_VH
`define BSCR_DEFINES_VH

`define BSCR_FRAME_BITS    13
`define BSCR_DATA_BITS     11
`define BSCR_ADDR_BITS     2
`define BSCR_BANK_COUNT    4
// bank addresses, bit 0 is lsb
`define BSCR_BANK_FILT     2'h0
`define BSCR_BANK_SYNTH    2'h1
`define BSCR_BANK_POWER    2'h2
`define BSCR_BANK_MISC     2'h3
// power-on values, latch bit n holds frame position n+2
`define BSCR_POR_FILT      11'h0ef
`define BSCR_POR_SYNTH     11'h041
`define BSCR_POR_POWER     11'h00f
`define BSCR_POR_MISC      11'h7b8
`define BSCR_SYNC_STAGES   2

`endif

// ==== hdl/bscr_sync.v ====
// bscr_sync.v: two-flop synchroniser for one asynchronous level
// assumes: clock is the local clock, rst_n already synchronous-released
`timescale 1ns/1ps
module bscr_sync (
   input  wire clock,
   input  wire rst_n,
   input  wire async_in,
   output reg  sync_out
);
   reg stage1;

   // first stage feeds only the second stage
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ==== hdl/bscr_top.v ====
// bscr_top.v: serial control register, 13-bit frame shifted on a link clock
//   into four banks of 11 latches, with a daisy-chain serial output
// assumes: link pins are asynchronous to clock (250 MHz) and are sampled;
//   link clock much slower than clock (84 ns or 204 ns period in the bench)
// How it works
// - thirteen stage shift register, data plus address
// - four banks of eleven latches each
// - shift data on link rising edge while low
// - select rising edge copies data into addressed bank
// - shift register frozen while select is high
// - positions two-twelve data, zero-one bank address
// - banks preset at power-up and sleep exit
// - outgoing shift bit drives chained serial output
// - shift stages unreset, output valid after thirteen
// - address bit zero lsb, bit one msb
// - bank zero: cutoff, equalizer, servo enable
// - bank one: feedback and input dividers
// - bank two: power downs, synth enable, delay
// - both address bits high select bank three
// - bank two: strobe sign, magnitude, pump gain
`timescale 1ns/1ps
`include "bscr_defines.vh"
module bscr_top #(
   parameter FRAME_BITS = `BSCR_FRAME_BITS,
   parameter DATA_BITS  = `BSCR_DATA_BITS
) (
   input  wire                 clock,
   input  wire                 arst_n,
   input  wire                 serial_cfg_clk,
   input  wire                 serial_cfg_in,
   input  wire                 latch_shift_select,
   input  wire                 sleep_n,
   input  wire                 idle_servo,
   output reg                  serial_cfg_out,
   output reg  [DATA_BITS-1:0] filter_equalizer_bank,
   output reg  [DATA_BITS-1:0] synthesizer_divider_bank,
   output reg  [DATA_BITS-1:0] power_and_delay_bank,
   output reg  [DATA_BITS-1:0] misc_bank,
   output wire [6:0]           cutoff_sel,
   output wire [2:0]           equalizer_sel,
   output wire                 servo_bw_enable,
   output wire [5:0]           synth_feedback_div,
   output wire [4:0]           synth_input_div,
   output wire                 synchronizer_power_off,
   output wire                 synthesizer_power_off,
   output wire                 pulse_detector_power_off,
   output wire                 synth_output_enable_n,
   output wire                 gating_delay_lsb,
   output wire                 strobe_offset_sign,
   output wire [2:0]           strobe_magnitude,
   output wire                 charge_pump_gain_sel
);

   ////////////////////////////////////////////////////////////////////////
   // reset release and input synchronisers

   reg rst_meta;
   reg rst_n;

   // release reset through two flops, assert it at once
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   wire clk_s;
   wire data_s;
   wire sel_s;
   wire sleep_n_s;
   wire idle_s;

   bscr_sync u_sync_clk (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (serial_cfg_clk),
      .sync_out (clk_s)
   );
   bscr_sync u_sync_data (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (serial_cfg_in),
      .sync_out (data_s)
   );
   bscr_sync u_sync_sel (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (latch_shift_select),
      .sync_out (sel_s)
   );
   bscr_sync u_sync_sleep (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (sleep_n),
      .sync_out (sleep_n_s)
   );
   bscr_sync u_sync_idle (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (idle_servo),
      .sync_out (idle_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // edge detection on synchronised levels

   reg clk_d;
   reg sel_d;
   reg sleep_n_d;

   // select delay resets high, but sel_s resets low, so a high select pin still gives one sel_rise after reset release, while preset is set
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_d     <= 1'b0;
         sel_d     <= 1'b1;
         sleep_n_d <= 1'b0;
      end else begin
         clk_d     <= clk_s;
         sel_d     <= sel_s;
         sleep_n_d <= sleep_n_s;
      end
   end

   // data and link clock pass equal delay, so data is sampled at its edge
   wire link_rise  = clk_s & ~clk_d;
   wire sel_rise   = sel_s & ~sel_d;
   wire sleep_exit = sleep_n_s & ~sleep_n_d;
   // loading only while sleep is off and idle/servo is low
   wire load_ok    = sleep_n_s & ~idle_s;

   ////////////////////////////////////////////////////////////////////////
   // shift register, deliberately without reset

   reg [FRAME_BITS-1:0] shifter;

   // new bit enters position 0; the bit leaving position 12 is the chain
   // output; unreset contents stay unknown until a full frame is in
   always @(posedge clock) begin
      if (link_rise && !sel_s && load_ok)
         shifter <= {shifter[FRAME_BITS-2:0], data_s};
   end

   // chained output follows the oldest stage
   always @(posedge clock) begin
      serial_cfg_out <= shifter[FRAME_BITS-1];
   end

   ////////////////////////////////////////////////////////////////////////
   // bank decode and latches

   // position 0 is the address lsb, position 1 the msb
   function [1:0] bank_of;
      input [FRAME_BITS-1:0] frame;
      begin
         bank_of = {frame[1], frame[0]};
      end
   endfunction

   wire [1:0]           bank_sel = bank_of(shifter);
   wire [DATA_BITS-1:0] payload  = shifter[FRAME_BITS-1:2];
   wire                 do_latch = sel_rise & load_ok;
   // power-on preset: while asleep, or sleep being left
   wire                 preset   = sleep_exit | ~sleep_n_s;

   // one bank rewritten per latch edge, the others keep their values
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         filter_equalizer_bank    <= `BSCR_POR_FILT;
         synthesizer_divider_bank <= `BSCR_POR_SYNTH;
         power_and_delay_bank     <= `BSCR_POR_POWER;
         misc_bank                <= `BSCR_POR_MISC;
      end else if (preset) begin
         filter_equalizer_bank    <= `BSCR_POR_FILT;
         synthesizer_divider_bank <= `BSCR_POR_SYNTH;
         power_and_delay_bank     <= `BSCR_POR_POWER;
         misc_bank                <= `BSCR_POR_MISC;
      end else if (do_latch) begin
         case (bank_sel)
            `BSCR_BANK_FILT:  filter_equalizer_bank    <= payload;
            `BSCR_BANK_SYNTH: synthesizer_divider_bank <= payload;
            `BSCR_BANK_POWER: power_and_delay_bank     <= payload;
            `BSCR_BANK_MISC:  misc_bank                <= payload;
            default:          misc_bank                <= misc_bank;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // field map, latch bit n is frame position n+2

   // bank 0: positions 2..8 cutoff, 9..11 equalizer, 12 servo enable
   assign cutoff_sel      = filter_equalizer_bank[6:0];
   assign equalizer_sel   = filter_equalizer_bank[9:7];
   assign servo_bw_enable = filter_equalizer_bank[10];

   // bank 1: positions 2..7 feedback divider, 8..12 input divider
   assign synth_feedback_div = synthesizer_divider_bank[5:0];
   assign synth_input_div    = synthesizer_divider_bank[10:6];

   // bank 2: power downs, synth enable, delay lsb, strobe and pump gain
   assign synchronizer_power_off   = power_and_delay_bank[0];
   assign synthesizer_power_off    = power_and_delay_bank[1];
   assign pulse_detector_power_off = power_and_delay_bank[2];
   assign synth_output_enable_n    = power_and_delay_bank[3];
   assign gating_delay_lsb         = power_and_delay_bank[4];
   assign strobe_offset_sign       = power_and_delay_bank[6];
   assign strobe_magnitude         = power_and_delay_bank[9:7];
   assign charge_pump_gain_sel     = power_and_delay_bank[10];

endmodule

// ==== test/bscr_props.sv ====
// bscr_props.sv: assertions on the ports of bscr_top
// assumes: bound into bscr_top, one clock domain, arst_n active low
`timescale 1ns/1ps
module bscr_props #(
   parameter DATA_BITS = 11
) (
   input logic                 clock,
   input logic                 arst_n,
   input logic                 latch_shift_select,
   input logic                 sleep_n,
   input logic                 idle_servo,
   input logic                 serial_cfg_out,
   input logic [DATA_BITS-1:0] filter_equalizer_bank,
   input logic [DATA_BITS-1:0] synthesizer_divider_bank,
   input logic [DATA_BITS-1:0] power_and_delay_bank,
   input logic [DATA_BITS-1:0] misc_bank,
   input logic [6:0]           cutoff_sel,
   input logic [2:0]           equalizer_sel,
   input logic                 servo_bw_enable,
   input logic [5:0]           synth_feedback_div,
   input logic [4:0]           synth_input_div,
   input logic                 synchronizer_power_off,
   input logic                 synthesizer_power_off,
   input logic                 pulse_detector_power_off,
   input logic                 synth_output_enable_n,
   input logic                 gating_delay_lsb,
   input logic                 strobe_offset_sign,
   input logic [2:0]           strobe_magnitude,
   input logic                 charge_pump_gain_sel
);
   localparam logic [43:0] POR = {11'h7b8, 11'h00f, 11'h041, 11'h0ef};
   logic [43:0] banks;
   logic        frame_seen;
   // the chained output stays unknown until a whole frame has been shifted
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         frame_seen <= 1'b0;
      end else if ($rose(latch_shift_select)) begin
         frame_seen <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // all four banks side by side, bank 0 lowest
   assign banks = {misc_bank, power_and_delay_bank, synthesizer_divider_bank,
                   filter_equalizer_bank};
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // sync delay on the pins is two clocks, three to the banks, so eight cycles leave margin
   property p_por; $rose(arst_n) |-> banks == POR; endproperty
   a_por: assert property (p_por) else $error("banks not preset at reset");
   property p_sleep; !sleep_n [*8] |-> banks == POR; endproperty
   a_sleep: assert property (p_sleep) else $error("banks not preset in sleep");
   property p_f0;
      {servo_bw_enable, equalizer_sel, cutoff_sel} == filter_equalizer_bank;
   endproperty
   a_f0: assert property (p_f0) else $error("bank 0 fields wrong");
   property p_f1; {synth_input_div, synth_feedback_div} == synthesizer_divider_bank;
   endproperty
   a_f1: assert property (p_f1) else $error("bank 1 fields wrong");
   property p_f2;
      {gating_delay_lsb, synth_output_enable_n, pulse_detector_power_off,
       synthesizer_power_off, synchronizer_power_off} == power_and_delay_bank[4:0];
   endproperty
   a_f2: assert property (p_f2) else $error("bank 2 low fields wrong");
   property p_f3;
      {charge_pump_gain_sel, strobe_magnitude, strobe_offset_sign}
         == power_and_delay_bank[10:6];
   endproperty
   a_f3: assert property (p_f3) else $error("bank 2 high fields wrong");
   property p_hold; (!latch_shift_select && sleep_n) [*8] |=> $stable(banks); endproperty
   a_hold: assert property (p_hold) else $error("bank moved while shifting");
   property p_idle; (idle_servo && sleep_n) [*8] |=> $stable(banks); endproperty
   a_idle: assert property (p_idle) else $error("bank loaded while idle");
   property p_freeze;
      (frame_seen && latch_shift_select) [*8] |=> $stable(serial_cfg_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("shifted while select high");
endmodule
bind bscr_top bscr_props #(.DATA_BITS(DATA_BITS)) u_props (.*);

// ==== test/bscr_ctl_model.sv ====
// bscr_ctl_model.sv: controller side of the serial configuration link
// assumes: clock is the bench clock; a link period is 2*h+1 clocks
`timescale 1ns/1ps
module bscr_ctl_model (
   input  logic clock,
   input  logic serial_cfg_out,
   output logic serial_cfg_clk,
   output logic serial_cfg_in,
   output logic latch_shift_select
);
   logic [12:0] echo;
   // link clock stands low between frames, select parked high to save power
   initial begin
      serial_cfg_clk     = 1'b0;
      serial_cfg_in      = 1'b0;
      latch_shift_select = 1'b1;
      echo               = 13'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // whole frame, position twelve first, address last, then latch
   task send_frame(input logic [12:0] f, input int h);
      @(posedge clock) latch_shift_select <= 1'b0;
      for (int i = 12; i >= 0; i--) begin
         @(posedge clock) serial_cfg_in <= f[i];
         repeat (h) @(posedge clock);
         echo           <= {echo[11:0], serial_cfg_out}; // chained bit seen
         serial_cfg_clk <= 1'b1;
         repeat (h) @(posedge clock);
         serial_cfg_clk <= 1'b0;
      end
      @(posedge clock) serial_cfg_in <= ~serial_cfg_in; // released, no stale level
      repeat (6) @(posedge clock);
      latch_shift_select <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
endmodule

// ==== test/tb_top.sv ====
// tb_top.sv: self-checking bench for bscr_top
// assumes: bscr_ctl_model drives the link, bscr_props bound to the top
`timescale 1ns/1ps
module tb_top;
   logic        clock, arst_n, sleep_n, idle_servo, serial_cfg_out;
   logic        serial_cfg_clk, serial_cfg_in, latch_shift_select;
   logic [10:0] b0, b1, b2, b3;
   logic [43:0] banks;
   int          n_errors = 0;
   int          compares = 0;
   localparam logic [43:0] POR = {11'h7b8, 11'h00f, 11'h041, 11'h0ef};
   logic [10:0] d [4] = '{11'h2a5, 11'h5a3, 11'h1c6, 11'h639};
   assign banks = {b3, b2, b1, b0};
   bscr_top u_dut (
      .clock(clock), .arst_n(arst_n), .serial_cfg_clk(serial_cfg_clk),
      .serial_cfg_in(serial_cfg_in), .latch_shift_select(latch_shift_select),
      .sleep_n(sleep_n), .idle_servo(idle_servo), .serial_cfg_out(serial_cfg_out),
      .filter_equalizer_bank(b0), .synthesizer_divider_bank(b1),
      .power_and_delay_bank(b2), .misc_bank(b3), .cutoff_sel(), .equalizer_sel(),
      .servo_bw_enable(), .synth_feedback_div(), .synth_input_div(),
      .synchronizer_power_off(), .synthesizer_power_off(), .pulse_detector_power_off(),
      .synth_output_enable_n(), .gating_delay_lsb(), .strobe_offset_sign(),
      .strobe_magnitude(), .charge_pump_gain_sel()
   );
   bscr_ctl_model u_ctl (
      .clock(clock), .serial_cfg_out(serial_cfg_out), .serial_cfg_clk(serial_cfg_clk),
      .serial_cfg_in(serial_cfg_in), .latch_shift_select(latch_shift_select)
   );
   ////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [43:0] exp, input logic [43:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // a hang counts as a mismatch; the tests need well under 20 us
   initial begin
      #50000;
      n_errors++;
      print_verdict;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [43:0] exp;
      arst_n     = 1'b0;
      sleep_n    = 1'b1;
      idle_servo = 1'b0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (8) @(posedge clock);
      chk("por", POR, banks);
      exp = POR;
      // each bank in turn, fast and slow link; earlier banks must survive
      for (int a = 0; a < 4; a++) begin
         u_ctl.send_frame({d[a], a[1:0]}, 10 + 15 * a[0]);
         exp[a*11 +: 11] = d[a];
         chk("banks", exp, banks);
         if (a > 0) chk("chain", {d[a-1], 2'(a - 1)}, u_ctl.echo);
      end
      idle_servo <= 1'b1;
      u_ctl.send_frame(13'h0000, 10);
      chk("idle", exp, banks);
      idle_servo <= 1'b0;
      sleep_n    <= 1'b0;
      repeat (12) @(posedge clock);
      chk("sleep", POR, banks);
      sleep_n <= 1'b1;
      repeat (12) @(posedge clock);
      chk("wake", POR, banks);
      u_ctl.send_frame({11'h7ff, 2'h2}, 10);
      exp         = POR;
      exp[32:22]  = 11'h7ff;
      chk("reload", exp, banks);
      print_verdict;
   end
endmodule
